// >>> tx_command_frame_extractor.sv
// Purpose: read side of the transmit FIFO; strips both command words, checks
//          them, and forwards frame words with byte enables to the MAC side
// Assumes: source words arrive in buffer order; inputs synchronous to clk
// Notes:   any command error stops the parser until reset

`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE1: checksum only with request, first segment, enable
// RULE2: host sets checksum request in first buffer
// RULE3: crc suppression bit stops crc append
// RULE4: pad suppression bit stops short frame padding
// RULE5: pad suppression always keeps the crc
// RULE6: host puts frame byte count in bits 10:0
// RULE7: length mismatch sets transmitter error flag
// RULE8: frame length bounds bytes moved to mac
// RULE9: last word byte enables drop trailing bytes
// RULE10: payload starts after the two command words
// RULE11: start offset picks first valid byte lane
// RULE12: bytes contiguous, unused tail bytes discarded
// RULE13: host sends first command word with fields
// RULE14: second command word must match across buffers
// RULE15: reserved command bits are ignored
module tx_command_frame_extractor
  import tx_frame_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // configuration
  input  wire logic              tx_checksum_engine_enable,
  // transmit data FIFO read side
  input  wire logic              src_valid,
  input  wire logic [WORD_W-1:0] src_data,
  output logic                   src_ready,
  // mac transmit layer
  output logic                   mac_valid,
  output logic      [WORD_W-1:0] mac_data,
  output logic      [LANES-1:0]  mac_byte_en,
  output logic                   mac_sof,
  output logic                   mac_eof,
  output logic                   mac_checksum,
  output logic                   mac_crc_add,
  output logic                   mac_pad_en,
  input  wire logic              mac_ready,
  // status
  output logic                   transmitter_error_flag
);

  generate
    if (DEPTH < 2) begin : g_bad_depth
      $error("tx_command_frame_extractor needs DEPTH >= 2");
    end
  endgenerate

  // ==========================================================================
  // parser state
  typedef struct packed {
    parse_state_t     state;
    logic [1:0]       ofs;
    logic             first_seg;
    logic             last_seg;
    logic [LEN_W-1:0] buf_rem;
    logic [LEN_W-1:0] frame_rem;
    logic             in_frame;
    logic             sof_pend;
    logic [31:0]      cmd_b;
    logic             chk;
    logic             crc_add;
    logic             pad_en;
    logic             tx_err;
  } parse_reg_t;

  parse_reg_t       st_reg;
  parse_reg_t       st_next;

  logic             take;
  logic             push;
  logic             err;
  logic [LEN_W-1:0] rem_now;
  logic [2:0]       avail;
  logic [2:0]       cnt;
  logic [LANES-1:0] be;
  logic             eof;
  logic [ENTRY_W-1:0] push_entry;
  logic [ENTRY_W-1:0] head_entry;

  assign take = src_valid && src_ready;

  // bytes of this word that belong to the buffer
  assign avail = BYTES_PER_WORD - {1'b0, st_reg.ofs};  // RULE11
  assign cnt   = (st_reg.buf_rem < LEN_W'(avail)) ? st_reg.buf_rem[2:0] : avail;  // RULE12
  assign eof   = (st_reg.frame_rem == LEN_W'(cnt));  // RULE8

  // frame bytes still owed, seen from the second command word of a buffer
  assign rem_now = st_reg.in_frame ? st_reg.frame_rem : src_data[FRAME_LEN_MSB:0];  // RULE6

  lane_mask u_lane_mask (
    .first_lane (st_reg.ofs),
    .lane_count (cnt),
    .byte_en    (be)
  );  // RULE9

  // ==========================================================================
  // command decode and data accounting
  always_comb begin
    st_next = st_reg;
    push    = 1'b0;
    err     = 1'b0;
    case (st_reg.state)
      ST_CMD_A: begin
        if (take) begin
          // reserved bits of the word are never looked at
          st_next.ofs     = src_data[OFS_MSB:OFS_LSB];  // RULE13
          st_next.first_seg = src_data[FIRST_SEG_BIT];
          st_next.last_seg  = src_data[LAST_SEG_BIT];
          st_next.buf_rem = src_data[BUF_SIZE_MSB:0];
          if (src_data[BUF_SIZE_MSB:0] == '0) begin
            err = 1'b1;
          end
          if (!st_reg.in_frame && !src_data[FIRST_SEG_BIT]) begin
            err = 1'b1;
          end
          if (st_reg.in_frame && src_data[FIRST_SEG_BIT]) begin
            err = 1'b1;
          end
          st_next.state = ST_CMD_B;
        end
      end
      ST_CMD_B: begin
        if (take) begin
          if (!st_reg.in_frame) begin
            st_next.cmd_b     = src_data & CMD_B_MATCH_MASK;  // RULE15
            st_next.frame_rem = src_data[FRAME_LEN_MSB:0];
            // request bit honoured from the first buffer only
            st_next.chk       = src_data[CHECKSUM_REQ_BIT] && st_reg.first_seg &&
                                tx_checksum_engine_enable;  // RULE1 RULE2
            st_next.crc_add   = src_data[PAD_OFF_BIT] || !src_data[CRC_OFF_BIT];  // RULE3 RULE5
            st_next.pad_en    = !src_data[PAD_OFF_BIT];  // RULE4
            st_next.sof_pend  = 1'b1;
            st_next.in_frame  = 1'b1;
          end else if (((src_data ^ st_reg.cmd_b) & CMD_B_MATCH_MASK) != '0) begin
            err = 1'b1;  // RULE14
          end
          // buffer sizes must add up exactly to the frame length
          if (st_reg.buf_rem > rem_now) begin
            err = 1'b1;  // RULE7
          end
          if (st_reg.buf_rem < rem_now && st_reg.last_seg) begin
            err = 1'b1;  // RULE7
          end
          if (st_reg.buf_rem == rem_now && !st_reg.last_seg) begin
            err = 1'b1;  // RULE7
          end
          st_next.state = ST_DATA;  // RULE10
        end
      end
      ST_DATA: begin
        if (take) begin
          push              = 1'b1;
          st_next.buf_rem   = st_reg.buf_rem - LEN_W'(cnt);
          st_next.frame_rem = st_reg.frame_rem - LEN_W'(cnt);  // RULE8
          st_next.ofs       = 2'h0;
          st_next.sof_pend  = 1'b0;
          if (st_reg.buf_rem == LEN_W'(cnt)) begin
            // rest of the word is alignment filler and is dropped
            st_next.state = ST_CMD_A;  // RULE12
            if (eof) begin
              st_next.in_frame = 1'b0;
            end
          end
        end
      end
      ST_HALT: begin
        // out of sync: swallow everything until reset
        st_next.state = ST_HALT;
      end
      default: begin
        st_next.state = ST_HALT;
      end
    endcase
    if (err) begin
      st_next.state = ST_HALT;
      st_next.tx_err = 1'b1;  // RULE7 RULE14
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg       <= '0;
      st_reg.state <= ST_CMD_A;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // output buffering; its ready throttles the source in every state
  assign push_entry = {st_reg.chk, st_reg.crc_add, st_reg.pad_en,
                       st_reg.sof_pend, eof, be, src_data};  // RULE9

  entry_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH)
  ) u_entry_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_data   (push_entry),
    .in_ready  (src_ready),
    .out_valid (mac_valid),
    .out_data  (head_entry),
    .out_ready (mac_ready)
  );

  assign mac_data     = head_entry[WORD_W-1:0];
  assign mac_byte_en  = head_entry[WORD_W +: LANES];
  assign mac_eof      = head_entry[WORD_W + LANES];
  assign mac_sof      = head_entry[WORD_W + LANES + 1];
  assign mac_pad_en   = head_entry[WORD_W + LANES + 2];
  assign mac_crc_add  = head_entry[WORD_W + LANES + 3];
  assign mac_checksum = head_entry[WORD_W + LANES + 4];

  assign transmitter_error_flag = st_reg.tx_err;

endmodule : tx_command_frame_extractor

`default_nettype wire

// >>> tx_frame_pkg.sv
// Purpose: shared constants and types for the transmit command frame extractor
// Assumes: 32-bit words from the transmit data FIFO, low byte in bits 7:0
// Notes:   bit positions of both command words and the parser states live here

package tx_frame_pkg;

  // ==========================================================================
  // word geometry
  localparam int unsigned WORD_W         = 32;
  localparam int unsigned LANES          = 4;
  localparam int unsigned LEN_W          = 11;
  localparam logic [2:0]  BYTES_PER_WORD = 3'h4;
  localparam int unsigned MIN_FRAME_BYTES = 64;

  // ==========================================================================
  // first command word fields
  localparam int unsigned OFS_MSB      = 17;
  localparam int unsigned OFS_LSB      = 16;
  localparam int unsigned FIRST_SEG_BIT = 13;
  localparam int unsigned LAST_SEG_BIT  = 12;
  localparam int unsigned BUF_SIZE_MSB = 10;

  // ==========================================================================
  // second command word fields
  localparam int unsigned CHECKSUM_REQ_BIT = 14;
  localparam int unsigned CRC_OFF_BIT   = 13;
  localparam int unsigned PAD_OFF_BIT   = 12;
  localparam int unsigned FRAME_LEN_MSB = 10;
  // bits that must repeat in every buffer: 13, 12 and 10:0
  localparam logic [31:0] CMD_B_MATCH_MASK = 32'h0000_37ff;

  // ==========================================================================
  // output entry layout: {chk, crc_add, pad_en, sof, eof, be, data}
  localparam int unsigned ENTRY_W    = WORD_W + LANES + 5;
  localparam int unsigned FIFO_DEPTH = 4;

  // ==========================================================================
  // parser states
  typedef enum logic [1:0] {
    ST_CMD_A,
    ST_CMD_B,
    ST_DATA,
    ST_HALT
  } parse_state_t;

endpackage : tx_frame_pkg

// >>> lane_mask.sv
// Purpose: byte enable mask for one data word
// Assumes: offset plus count never passes the top lane
// Notes:   purely combinational, one term per lane

`timescale 1ns/10ps
`default_nettype none

module lane_mask
  import tx_frame_pkg::*;
(
  // selection
  input  wire logic [1:0]       first_lane,
  input  wire logic [2:0]       lane_count,
  // mask
  output logic      [LANES-1:0] byte_en
);

  logic [2:0] end_lane;

  assign end_lane = {1'b0, first_lane} + lane_count;

  // ==========================================================================
  // per-lane enable
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      assign byte_en[i] = (3'(i) >= {1'b0, first_lane}) && (3'(i) < end_lane);
    end
  endgenerate

endmodule : lane_mask

`default_nettype wire

// >>> entry_fifo.sv
// Purpose: small shift-register FIFO between the parser and the MAC side
// Assumes: one clock, push and pop may share a cycle
// Notes:   head entry and both handshakes come straight from flip-flops

`timescale 1ns/10ps
`default_nettype none

module entry_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
      $error("entry_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0]            vld;
    logic                        rdy;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        placed;

  // ==========================================================================
  // next state: shift on pop, then drop the new word into the lowest hole
  always_comb begin
    st_next = st_reg;
    placed  = 1'b0;
    if (st_reg.vld[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_next.mem[i] = st_reg.mem[i+1];
        st_next.vld[i] = st_reg.vld[i+1];
      end
      st_next.vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && st_reg.rdy) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !st_next.vld[i]) begin
          st_next.mem[i] = in_data;
          st_next.vld[i] = 1'b1;
          placed         = 1'b1;
        end
      end
    end
    // ready is taken from the state after this cycle, so it never over-admits
    st_next.rdy = !st_next.vld[DEPTH-1];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg     <= '0;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready  = st_reg.rdy;
  assign out_valid = st_reg.vld[0];
  assign out_data  = st_reg.mem[0];

endmodule : entry_fifo

`default_nettype wire

// >>> placeholder_end.sv
// Purpose: none
// Assumes: none
// Notes:   none

// >>> tx_command_frame_extractor_asserts.sv
// Purpose: port assertions for the frame extractor
// Assumes: one clock, rst_b asynchronous active low
// Notes:   bound to every instance of the extractor
`timescale 1ns/10ps
`default_nettype none
module tx_command_frame_extractor_asserts
  import tx_frame_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // watched ports
  input wire logic              src_ready,
  input wire logic              mac_valid,
  input wire logic [WORD_W-1:0] mac_data,
  input wire logic [LANES-1:0]  mac_byte_en,
  input wire logic              mac_sof,
  input wire logic              mac_eof,
  input wire logic              mac_checksum,
  input wire logic              mac_crc_add,
  input wire logic              mac_pad_en,
  input wire logic              mac_ready,
  input wire logic              transmitter_error_flag
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RESET_IDLE:
    assert property ($rose(rst_b) |-> src_ready && !mac_valid && !transmitter_error_flag)
    else $error("outputs not idle after reset");
  AST_HOLD:
    assert property (mac_valid && !mac_ready |=> mac_valid && $stable(mac_data)
                     && $stable(mac_byte_en) && $stable(mac_sof) && $stable(mac_eof))
    else $error("mac entry changed before it was taken");
  AST_EOF_THEN_SOF:
    assert property (mac_valid && mac_ready && mac_eof |=> !mac_valid || mac_sof)
    else $error("word after frame end does not start a frame");
  AST_FLAGS_STABLE:
    assert property (mac_valid && mac_ready && !mac_eof ##1 mac_valid |-> $stable(mac_checksum)
                     && $stable(mac_crc_add) && $stable(mac_pad_en))
    else $error("frame flags changed within a frame");
  AST_CRC_WHEN_PAD:
    assert property (mac_valid && !mac_pad_en |-> mac_crc_add)
    else $error("crc dropped while padding suppressed");
  AST_BE_CONTIG:
    assert property (mac_valid |-> mac_byte_en inside {4'h1, 4'h3, 4'h7, 4'hf, 4'h2, 4'h6,
                                                        4'he, 4'h4, 4'hc, 4'h8})
    else $error("byte enables empty or not contiguous");
  AST_ERR_STICKY:
    assert property (transmitter_error_flag |=> transmitter_error_flag)
    else $error("error flag cleared without reset");
  AST_FULL_VALID:
    assert property (!src_ready |-> mac_valid)
    else $error("source refused while output empty");

  cover property (mac_valid && mac_sof && mac_eof);
  cover property ($rose(transmitter_error_flag));
  cover property (!src_ready && !mac_ready);
endmodule : tx_command_frame_extractor_asserts

bind tx_command_frame_extractor tx_command_frame_extractor_asserts
  tx_command_frame_extractor_asserts_inst (.clk(clk), .rst_b(rst_b), .src_ready(src_ready),
  .mac_valid(mac_valid), .mac_data(mac_data), .mac_byte_en(mac_byte_en), .mac_sof(mac_sof),
  .mac_eof(mac_eof), .mac_checksum(mac_checksum), .mac_crc_add(mac_crc_add),
  .mac_pad_en(mac_pad_en), .mac_ready(mac_ready),
  .transmitter_error_flag(transmitter_error_flag));
`default_nettype wire

// >>> host_bulk_out_model.sv
// Purpose: host side that writes command-prefixed buffers into the FIFO
// Assumes: words are queued by the bench in buffer order
// Notes:   slow mode inserts random idle cycles
`timescale 1ns/10ps
`default_nettype none
module host_bulk_out_model
  import tx_frame_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // pacing
  input  wire logic              slow,
  // fifo write side
  input  wire logic              src_ready,
  output logic                   src_valid,
  output logic      [WORD_W-1:0] src_data
);
  logic [WORD_W-1:0] words[$];

  task automatic put(input logic [WORD_W-1:0] w);
    words.push_back(w);
  endtask : put

  // ==========================================================================
  // a word stands until taken; idle data toggles so stale words never match
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_valid <= 1'b0;
      src_data  <= '0;
    end else if (!src_valid || src_ready) begin
      if (words.size() != 0 && !(slow && $urandom_range(1, 0) == 0)) begin
        src_valid <= 1'b1;
        src_data  <= words.pop_front();
      end else begin
        src_valid <= 1'b0;
        src_data  <= ~src_data;
      end
    end
  end
endmodule : host_bulk_out_model
`default_nettype wire

// >>> test_tx_command_frame_extractor.sv
// Purpose: self-checking bench for the frame extractor
// Assumes: host model feeds words, mac side ready is always high, random or held low by rmode
// Notes:   expected bytes and flags are worked out by bench functions
`timescale 1ns/10ps
`default_nettype none
module test_tx_command_frame_extractor
  import tx_frame_pkg::*;
;
  logic        clk, rst_b, en, slow, mac_ready, src_valid, src_ready, mac_valid;
  logic        sof, eof, chk, crc, pad, err, mon_on;
  logic [31:0] src_data, mac_data;
  logic [3:0]  be;
  logic [7:0]  exp_b[$];
  logic [2:0]  exp_f[$];
  int          exp_n[$];
  int          fail_count, tests_run, rmode, seed, nb_seen;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  tx_command_frame_extractor #(.DEPTH(FIFO_DEPTH)) tx_command_frame_extractor_inst (
    .clk(clk), .rst_b(rst_b), .tx_checksum_engine_enable(en), .src_valid(src_valid),
    .src_data(src_data), .src_ready(src_ready), .mac_valid(mac_valid), .mac_data(mac_data),
    .mac_byte_en(be), .mac_sof(sof), .mac_eof(eof), .mac_checksum(chk), .mac_crc_add(crc),
    .mac_pad_en(pad), .mac_ready(mac_ready), .transmitter_error_flag(err));
  host_bulk_out_model host_bulk_out_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow),
    .src_ready(src_ready), .src_valid(src_valid), .src_data(src_data));

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // c is {checksum request, crc off, pad off}; result {checksum, crc add, pad}
  function automatic logic [2:0] flags(input logic [2:0] c, input logic e);
    return {c[2] & e, c[0] | ~c[1], ~c[0]};
  endfunction : flags

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // bad 1: length field one above supplied bytes; bad 2: second command differs
  task automatic send_frame(input int len, input int nbuf, input logic [2:0] c, input int bad);
    int          left, sz, ofs, k;
    logic [31:0] w;
    logic [7:0]  d;
    left = len;
    if (bad == 0) begin
      exp_n.push_back(len);
      exp_f.push_back(flags(c, en));
    end
    for (int b = 0; b < nbuf; b++) begin
      sz = (b == nbuf - 1) ? left : $urandom_range(left - nbuf + b + 1, 1);
      left -= sz;
      ofs = $urandom_range(3, 0);
      host_bulk_out_model_inst.put({14'h0, ofs[1:0], 2'h0, b == 0, b == nbuf - 1, 1'b0,
                                    sz[10:0]});
      w = {17'h0, c[2] & (b == 0), c[1] ^ (bad == 2 && b == 1), c[0], 1'b0,
           len[10:0] + 11'(bad == 1)};
      host_bulk_out_model_inst.put(w);
      w = $urandom;
      for (k = ofs; k < ofs + sz; k++) begin
        d = 8'($urandom);
        if (bad == 0)
          exp_b.push_back(d);
        w[(k % 4) * 8 +: 8] = d;
        if (k % 4 == 3 || k == ofs + sz - 1) begin
          host_bulk_out_model_inst.put(w);
          w = $urandom;
        end
      end
    end
  endtask : send_frame

  task automatic wait_done(input bit good);
    int t;
    for (t = 0; t < 20000; t++) begin
      @(negedge clk);
      if (host_bulk_out_model_inst.words.size() == 0 && !src_valid && !mac_valid
          && (!good || exp_b.size() == 0))
        break;
    end
    if (t == 20000) begin
      check("timeout", 1, 0);
      complete_run();
    end
    repeat (4) @(posedge clk);
  endtask : wait_done

  // ==========================================================================
  // mac side: ready always high, random or held low by rmode, monitor looks at settled values
  always @(posedge clk)
    mac_ready <= (rmode == 0) || (rmode == 1 && $urandom_range(1, 0) == 1);

  always @(negedge clk) begin
    if (rst_b && mon_on && mac_valid && mac_ready) begin
      if (sof) begin
        check("flags", 32'({chk, crc, pad}), 32'(exp_f.pop_front()));
        nb_seen = 0;
      end
      for (int i = 0; i < 4; i++)
        if (be[i]) begin
          check("byte", mac_data[i*8 +: 8], exp_b.pop_front());
          nb_seen++;
        end
      if (eof)
        check("length", nb_seen, exp_n.pop_front());
    end
  end

  // ==========================================================================
  // sequence
  initial begin
    seed = $urandom(32'h8004);
    {rst_b, en, slow, mac_ready, rmode, mon_on, fail_count, tests_run, nb_seen} = '0;
    mon_on = 1'b1;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    // every flag combination, both enable levels, lengths 1 and 61 to 67, back to back
    for (int e = 0; e < 2; e++) begin
      en <= e[0];
      @(posedge clk);
      for (int c = 0; c < 8; c++)
        send_frame(c == 0 ? 1 : 60 + c, 1 + c % 3, c[2:0], 0);
      wait_done(1);
    end
    slow <= 1'b1;
    rmode = 1;
    for (int i = 0; i < 40; i++)
      send_frame($urandom_range(200, 3), $urandom_range(3, 1), 3'($urandom), 0);
    wait_done(1);
    // stall the mac side until the fifo refuses, then drain
    rmode = 2;
    send_frame(40, 1, 3'h0, 0);
    repeat (30) @(negedge clk);
    check("src_ready", src_ready, 0);
    rmode = 1;
    wait_done(1);
    check("error", err, 0);
    mon_on = 1'b0;
    send_frame(5, 1, 3'h0, 1);
    wait_done(0);
    check("error", err, 1);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("error", err, 0);
    send_frame(8, 2, 3'h0, 2);
    wait_done(0);
    check("error", err, 1);
    complete_run();
  end
endmodule : test_tx_command_frame_extractor
`default_nettype wire
